// *** smi_led_pkg.sv ***
package smi_led_pkg;

  // ==========================================================
  // Register indices
  localparam logic [7:0] ADDR_SMI_CONTROL_ONE      = 8'hf0;
  localparam logic [7:0] ADDR_SMI_CONTROL_TWO      = 8'hf1;
  localparam logic [7:0] ADDR_SMI_STATUS_ONE       = 8'hf2;
  localparam logic [7:0] ADDR_SMI_STATUS_TWO       = 8'hf3;
  localparam logic [7:0] ADDR_SMI_PIN_SELECT       = 8'hf4;
  localparam logic [7:0] ADDR_SPARE_F5             = 8'hf5;
  localparam logic [7:0] ADDR_SPARE_F6             = 8'hf6;
  localparam logic [7:0] ADDR_KBD_LOCK_PIN_SELECT  = 8'hf7;
  localparam logic [7:0] ADDR_BLINK1_PIN_SELECT    = 8'hf8;
  localparam logic [7:0] ADDR_BLINK1_CONTROL       = 8'hf9;
  localparam logic [7:0] ADDR_BLINK2_PIN_SELECT    = 8'hfa;
  localparam logic [7:0] ADDR_BLINK2_CONTROL       = 8'hfb;
  localparam logic [7:0] ADDR_VOLTAGE_CODE_IN      = 8'hfc;
  localparam logic [7:0] ADDR_VOLTAGE_CODE_OUT     = 8'hfd;

  // ==========================================================
  // Field layouts and reset values
  localparam logic [7:0] RESET_VALUE       = 8'h00;
  localparam int         PERIPH_COUNT      = 8;
  localparam int         MISC_COUNT        = 3;
  localparam int         SRC_COUNT         = 11;
  localparam int         GLOBAL_CLEAR_BIT  = 7;
  localparam int         LEVEL_MODE_BIT    = 6;
  localparam int         LOC_WIDTH         = 6;
  localparam int         PINS_PER_SET      = 8;
  localparam int         PIN_COUNT         = 40;
  localparam int         FIRST_SET         = 1;
  localparam int         LED_CTRL_WIDTH    = 4;
  localparam int         SHORT_PULSE_BIT   = 3;
  localparam int         FREQ_MSB          = 2;
  localparam int         FREQ_LSB          = 1;
  localparam int         LOW_EN_BIT        = 0;
  localparam int         VOLTAGE_WIDTH     = 6;
  localparam int         VOLTAGE_DRIVE_BIT = 7;

  // ==========================================================
  // Timing
  localparam int CLK_FREQ_HZ       = 100_000_000;
  localparam int BLINK_TICK_MS     = 125;
  localparam int BLINK_TICK_CYCLES = CLK_FREQ_HZ / 1000 * BLINK_TICK_MS;
  localparam int TICK_CNT_WIDTH    = 24;
  localparam int PERIOD_4HZ_MS     = 250;
  localparam int PERIOD_1HZ_MS     = 1000;
  localparam int PERIOD_QUARTER_MS = 4000;
  localparam int PERIOD_EIGHTH_MS  = 8000;
  localparam logic [5:0] LAST_TICK_4HZ     = 6'(PERIOD_4HZ_MS / BLINK_TICK_MS - 1);
  localparam logic [5:0] LAST_TICK_1HZ     = 6'(PERIOD_1HZ_MS / BLINK_TICK_MS - 1);
  localparam logic [5:0] LAST_TICK_QUARTER = 6'(PERIOD_QUARTER_MS / BLINK_TICK_MS - 1);
  localparam logic [5:0] LAST_TICK_EIGHTH  = 6'(PERIOD_EIGHTH_MS / BLINK_TICK_MS - 1);
  localparam logic [1:0] FREQ_4HZ          = 2'h0;
  localparam logic [1:0] FREQ_1HZ          = 2'h1;
  localparam logic [1:0] FREQ_QUARTER      = 2'h2;
  localparam logic [1:0] FREQ_EIGHTH       = 2'h3;

endpackage

// *** pin_locator.sv ***
`timescale 1ns/1ps
`default_nettype none

module pin_locator
  import smi_led_pkg::*;
(
  // Location code
  input  wire logic [smi_led_pkg::LOC_WIDTH-1:0] code_in,
  // One-hot pin select
  output logic      [smi_led_pkg::PIN_COUNT-1:0] select_out
);

  // ==========================================================
  // Decode set number and bit; unlisted codes select nothing
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    localparam logic [2:0] SET_NUM = 3'(i / PINS_PER_SET + FIRST_SET);
    localparam logic [2:0] BIT_NUM = 3'(i % PINS_PER_SET);
    assign select_out[i] = (code_in == {SET_NUM, BIT_NUM});
  end

endmodule

`default_nettype wire

// *** blink_engine.sv ***
`timescale 1ns/1ps
`default_nettype none

module blink_engine
  import smi_led_pkg::*;
(
  // Clock and reset
  input  wire logic                                   clk_in,
  input  wire logic                                   rst_n_in,
  // Control
  input  wire logic                                   tick_in,
  input  wire logic [smi_led_pkg::LED_CTRL_WIDTH-1:0] control_in,
  // Waveform
  output logic                                        level_out,
  output logic                                        drive_out
);

  logic [5:0] phase;
  logic [5:0] last_tick;
  logic       next_level;

  // ==========================================================
  // Period select
  always_comb begin
    case (control_in[FREQ_MSB:FREQ_LSB])
      FREQ_4HZ:     last_tick = LAST_TICK_4HZ;
      FREQ_1HZ:     last_tick = LAST_TICK_1HZ;
      FREQ_QUARTER: last_tick = LAST_TICK_QUARTER;
      default:      last_tick = LAST_TICK_EIGHTH;
    endcase
  end

  // ==========================================================
  // Phase counter in ticks
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase <= 6'h00;
    end else if (tick_in) begin
      if (phase >= last_tick) begin
        phase <= 6'h00;
      end else begin
        phase <= phase + 6'h01;
      end
    end
  end

  // Low for the first half, or only the first tick in short mode
  always_comb begin
    if (control_in[SHORT_PULSE_BIT]) begin
      next_level = (phase != 6'h00);
    end else begin
      next_level = (phase > (last_tick >> 1));
    end
  end

  // ==========================================================
  // Output flops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_out <= 1'b1;
      drive_out <= 1'b0;
    end else begin
      level_out <= next_level;
      drive_out <= control_in[LOW_EN_BIT];
    end
  end

  property p_blink_off;
    @(posedge clk_in) disable iff (!rst_n_in)
      !control_in[LOW_EN_BIT] |=> !drive_out;
  endproperty
  a_blink_off: assert property (p_blink_off) else $error("blink drives while disabled");

  property p_short_pulse;
    @(posedge clk_in) disable iff (!rst_n_in)
      control_in[SHORT_PULSE_BIT] && phase != 6'h00 |=> level_out;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short pulse too long");

endmodule

`default_nettype wire

// *** smi_led_vid_config.sv ***
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module smi_led_vid_config
  import smi_led_pkg::*;
#(
  parameter int BLINK_TICK_CYCLES = smi_led_pkg::BLINK_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                                  clk_in,
  input  wire logic                                  rst_n_in,
  // Register port
  input  wire logic [7:0]                            addr_in,
  input  wire logic [7:0]                            wdata_in,
  input  wire logic                                  wr_in,
  input  wire logic                                  rd_in,
  output logic      [7:0]                            rdata_out,
  // Interrupt sources
  input  wire logic [smi_led_pkg::PERIPH_COUNT-1:0]  periph_irq_in,
  input  wire logic [smi_led_pkg::MISC_COUNT-1:0]    misc_irq_in,
  output logic                                       sys_mgmt_irq_out,
  // General purpose pins
  input  wire logic [smi_led_pkg::PIN_COUNT-1:0]     gp_pin_in,
  output logic      [smi_led_pkg::PIN_COUNT-1:0]     gp_level_out,
  output logic      [smi_led_pkg::PIN_COUNT-1:0]     gp_drive_out,
  output logic                                       kbd_lock_out,
  // Voltage code pins
  input  wire logic [smi_led_pkg::VOLTAGE_WIDTH-1:0] voltage_code_pin_in,
  output logic      [smi_led_pkg::VOLTAGE_WIDTH-1:0] voltage_code_level_out,
  output logic                                       voltage_code_drive_en_out
);

  // ==========================================================
  // Declarations
  logic [7:0]                  smi_control_one;
  logic                        level_mode;
  logic [MISC_COUNT-1:0]       misc_enable;
  logic [LOC_WIDTH-1:0]        smi_pin_select;
  logic [LOC_WIDTH-1:0]        kbd_lock_pin_select;
  logic [LOC_WIDTH-1:0]        blink1_pin_select;
  logic [LED_CTRL_WIDTH-1:0]   blink1_control;
  logic [LOC_WIDTH-1:0]        blink2_pin_select;
  logic [LED_CTRL_WIDTH-1:0]   blink2_control;
  logic                        voltage_drive;
  logic [VOLTAGE_WIDTH-1:0]    voltage_value;
  logic [SRC_COUNT-1:0]        sources;
  logic [SRC_COUNT-1:0]        sources_prev;
  logic [SRC_COUNT-1:0]        status;
  logic [SRC_COUNT-1:0]        next_status;
  logic [SRC_COUNT-1:0]        status_set;
  logic [SRC_COUNT-1:0]        status_clear;
  logic [SRC_COUNT-1:0]        enables;
  logic                        write_ctrl_one;
  logic                        write_ctrl_two;
  logic                        global_clear;
  logic                        read_status_one;
  logic                        read_status_two;
  logic [7:0]                  read_mux;
  logic [TICK_CNT_WIDTH-1:0]   tick_count;
  logic                        tick;
  logic [PIN_COUNT-1:0]        smi_sel;
  logic [PIN_COUNT-1:0]        kbd_sel;
  logic [PIN_COUNT-1:0]        blink1_sel;
  logic [PIN_COUNT-1:0]        blink2_sel;
  logic                        blink1_level;
  logic                        blink1_drive;
  logic                        blink2_level;
  logic                        blink2_drive;

  assign write_ctrl_one  = wr_in && (addr_in == ADDR_SMI_CONTROL_ONE);
  assign write_ctrl_two  = wr_in && (addr_in == ADDR_SMI_CONTROL_TWO);
  assign global_clear    = write_ctrl_two && wdata_in[GLOBAL_CLEAR_BIT];
  assign read_status_one = rd_in && (addr_in == ADDR_SMI_STATUS_ONE);
  assign read_status_two = rd_in && (addr_in == ADDR_SMI_STATUS_TWO);

  // ==========================================================
  // Writable registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      smi_control_one <= RESET_VALUE;
    end else if (write_ctrl_one) begin
      smi_control_one <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_mode  <= 1'b0;
      misc_enable <= '0;
    end else if (write_ctrl_two) begin
      level_mode  <= wdata_in[LEVEL_MODE_BIT];
      misc_enable <= wdata_in[MISC_COUNT-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      smi_pin_select      <= '0;
      kbd_lock_pin_select <= '0;
      blink1_pin_select   <= '0;
      blink1_control      <= '0;
      blink2_pin_select   <= '0;
      blink2_control      <= '0;
    end else if (wr_in) begin
      case (addr_in)
        ADDR_SMI_PIN_SELECT:      smi_pin_select      <= wdata_in[LOC_WIDTH-1:0];
        ADDR_KBD_LOCK_PIN_SELECT: kbd_lock_pin_select <= wdata_in[LOC_WIDTH-1:0];
        ADDR_BLINK1_PIN_SELECT:   blink1_pin_select   <= wdata_in[LOC_WIDTH-1:0];
        ADDR_BLINK1_CONTROL:      blink1_control      <= wdata_in[LED_CTRL_WIDTH-1:0];
        ADDR_BLINK2_PIN_SELECT:   blink2_pin_select   <= wdata_in[LOC_WIDTH-1:0];
        ADDR_BLINK2_CONTROL:      blink2_control      <= wdata_in[LED_CTRL_WIDTH-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      voltage_drive <= 1'b0;
      voltage_value <= '0;
    end else if (wr_in && (addr_in == ADDR_VOLTAGE_CODE_OUT)) begin
      voltage_drive <= wdata_in[VOLTAGE_DRIVE_BIT];
      voltage_value <= wdata_in[VOLTAGE_WIDTH-1:0];
    end
  end

  // ==========================================================
  // Interrupt status
  assign sources = {misc_irq_in, periph_irq_in};
  assign enables = {misc_enable, smi_control_one};

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sources_prev <= '0;
    end else begin
      sources_prev <= sources;
    end
  end

  always_comb begin
    if (level_mode) begin
      status_set = sources;
    end else begin
      status_set = sources & ~sources_prev;
    end
    status_clear = '0;
    if (global_clear) begin
      status_clear = '1;
    end
    if (read_status_one) begin
      status_clear[PERIPH_COUNT-1:0] = '1;
    end
    if (read_status_two) begin
      status_clear[SRC_COUNT-1:PERIPH_COUNT] = '1;
    end
    next_status = (status & ~status_clear) | status_set;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sys_mgmt_irq_out <= 1'b0;
    end else begin
      sys_mgmt_irq_out <= |(status & enables);
    end
  end

  // ==========================================================
  // Read path
  always_comb begin
    case (addr_in)
      ADDR_SMI_CONTROL_ONE:     read_mux = smi_control_one;
      ADDR_SMI_CONTROL_TWO:     read_mux = {1'b0, level_mode, 3'h0, misc_enable};
      ADDR_SMI_STATUS_ONE:      read_mux = status[PERIPH_COUNT-1:0];
      ADDR_SMI_STATUS_TWO:      read_mux = {5'h00, status[SRC_COUNT-1:PERIPH_COUNT]};
      ADDR_SMI_PIN_SELECT:      read_mux = {2'h0, smi_pin_select};
      ADDR_KBD_LOCK_PIN_SELECT: read_mux = {2'h0, kbd_lock_pin_select};
      ADDR_BLINK1_PIN_SELECT:   read_mux = {2'h0, blink1_pin_select};
      ADDR_BLINK1_CONTROL:      read_mux = {4'h0, blink1_control};
      ADDR_BLINK2_PIN_SELECT:   read_mux = {2'h0, blink2_pin_select};
      ADDR_BLINK2_CONTROL:      read_mux = {4'h0, blink2_control};
      ADDR_VOLTAGE_CODE_IN:     read_mux = {2'h0, voltage_code_pin_in};
      ADDR_VOLTAGE_CODE_OUT:    read_mux = {voltage_drive, 1'b0, voltage_value};
      default:                  read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= read_mux;
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ==========================================================
  // Blink tick
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_count <= '0;
      tick       <= 1'b0;
    end else if (tick_count >= TICK_CNT_WIDTH'(BLINK_TICK_CYCLES - 1)) begin
      tick_count <= '0;
      tick       <= 1'b1;
    end else begin
      tick_count <= tick_count + TICK_CNT_WIDTH'(1);
      tick       <= 1'b0;
    end
  end

  // ==========================================================
  // Pin routing
  pin_locator u_smi_loc (
    .code_in    (smi_pin_select),
    .select_out (smi_sel)
  );

  pin_locator u_kbd_loc (
    .code_in    (kbd_lock_pin_select),
    .select_out (kbd_sel)
  );

  pin_locator u_blink1_loc (
    .code_in    (blink1_pin_select),
    .select_out (blink1_sel)
  );

  pin_locator u_blink2_loc (
    .code_in    (blink2_pin_select),
    .select_out (blink2_sel)
  );

  blink_engine u_blink1 (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .tick_in    (tick),
    .control_in (blink1_control),
    .level_out  (blink1_level),
    .drive_out  (blink1_drive)
  );

  blink_engine u_blink2 (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .tick_in    (tick),
    .control_in (blink2_control),
    .level_out  (blink2_level),
    .drive_out  (blink2_drive)
  );

  // Interrupt pin is active low; it outranks both blink channels
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        gp_level_out[i] <= 1'b1;
        gp_drive_out[i] <= 1'b0;
      end else if (smi_sel[i]) begin
        gp_level_out[i] <= ~sys_mgmt_irq_out;
        gp_drive_out[i] <= 1'b1;
      end else if (blink1_sel[i]) begin
        gp_level_out[i] <= blink1_level;
        gp_drive_out[i] <= blink1_drive;
      end else if (blink2_sel[i]) begin
        gp_level_out[i] <= blink2_level;
        gp_drive_out[i] <= blink2_drive;
      end else begin
        gp_level_out[i] <= 1'b1;
        gp_drive_out[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      kbd_lock_out <= 1'b0;
    end else begin
      kbd_lock_out <= |(gp_pin_in & kbd_sel);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      voltage_code_level_out    <= '0;
      voltage_code_drive_en_out <= 1'b0;
    end else begin
      voltage_code_level_out    <= voltage_value;
      voltage_code_drive_en_out <= voltage_drive;
    end
  end

  // ==========================================================
  // Assertions
  property p_irq_follows;
    @(posedge clk_in) disable iff (!rst_n_in)
      |(status & enables) |=> sys_mgmt_irq_out;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt not raised");

  property p_irq_quiet;
    @(posedge clk_in) disable iff (!rst_n_in)
      (status & enables) == '0 |=> !sys_mgmt_irq_out;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("spurious interrupt");

  property p_global_clear;
    @(posedge clk_in) disable iff (!rst_n_in)
      global_clear && sources == '0 |=> status == '0;
  endproperty
  a_global_clear: assert property (p_global_clear) else $error("global clear failed");

  property p_edge_set;
    @(posedge clk_in) disable iff (!rst_n_in)
      !level_mode && sources[0] && !sources_prev[0] |=> status[0];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge not captured");

  property p_level_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
      level_mode && sources[1] |=> status[1];
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level not captured");

  property p_ctrl_one_write;
    @(posedge clk_in) disable iff (!rst_n_in)
      write_ctrl_one |=> smi_control_one == $past(wdata_in);
  endproperty
  a_ctrl_one_write: assert property (p_ctrl_one_write) else $error("control one lost");

  property p_spare_read;
    @(posedge clk_in) disable iff (!rst_n_in)
      rd_in && (addr_in == ADDR_SPARE_F5 || addr_in == ADDR_SPARE_F6) |=> rdata_out == 8'h00;
  endproperty
  a_spare_read: assert property (p_spare_read) else $error("spare register nonzero");

  property p_voltage_drive;
    @(posedge clk_in) disable iff (!rst_n_in)
      wr_in && addr_in == ADDR_VOLTAGE_CODE_OUT && wdata_in[VOLTAGE_DRIVE_BIT]
        |=> ##1 voltage_code_drive_en_out;
  endproperty
  a_voltage_drive: assert property (p_voltage_drive) else $error("voltage pins not driven");

  property p_voltage_read;
    @(posedge clk_in) disable iff (!rst_n_in)
      rd_in && addr_in == ADDR_VOLTAGE_CODE_IN
        |=> rdata_out == {2'h0, $past(voltage_code_pin_in)};
  endproperty
  a_voltage_read: assert property (p_voltage_read) else $error("voltage code misread");

  property p_status_two_read;
    @(posedge clk_in) disable iff (!rst_n_in)
      rd_in && addr_in == ADDR_SMI_STATUS_TWO |=> rdata_out[7:MISC_COUNT] == '0;
  endproperty
  a_status_two_read: assert property (p_status_two_read) else $error("reserved status bits");

endmodule

`default_nettype wire

// *** irq_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host side: counts assertions of the interrupt line
module irq_host_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Interrupt line
  input  wire logic       irq_in,
  output logic      [7:0] rise_count_out
);
  logic last;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last           <= 1'b0;
      rise_count_out <= 8'h00;
    end else begin
      last <= irq_in;
      if (irq_in && !last) begin
        rise_count_out <= rise_count_out + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// *** smi_led_vid_config_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Bench
module smi_led_vid_config_tb;
  import smi_led_pkg::*;
  localparam int TICK = 4;
  logic        clk_in, rst_n_in, wr, rd, irq, kbd, vdrive;
  logic [7:0]  addr, wdata, rdata, rises;
  logic [7:0]  periph;
  logic [2:0]  misc;
  logic [39:0] gp_pin, gp_level, gp_drive;
  logic [5:0]  vpin, vlevel;
  logic [10:0] en;
  int          err_total, num_checks, lows, falls, per;

  smi_led_vid_config #(.BLINK_TICK_CYCLES(TICK)) u_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .periph_irq_in(periph),
    .misc_irq_in(misc), .sys_mgmt_irq_out(irq), .gp_pin_in(gp_pin),
    .gp_level_out(gp_level), .gp_drive_out(gp_drive), .kbd_lock_out(kbd),
    .voltage_code_pin_in(vpin), .voltage_code_level_out(vlevel),
    .voltage_code_drive_en_out(vdrive));

  irq_host_model u_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .irq_in(irq),
    .rise_count_out(rises));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    chk(40'(rdata), 40'(exp));
  endtask

  task automatic set_src(input logic [7:0] p, input logic [2:0] m);
    @(posedge clk_in);
    periph <= p;
    misc   <= m;
    repeat (3) @(posedge clk_in);
    #1;
  endtask

  task automatic measure(input int idx);
    logic prev;
    lows  = 0;
    falls = 0;
    prev  = gp_level[idx];
    repeat (512) begin
      @(posedge clk_in);
      #1;
      if (gp_level[idx] === 1'b0) lows++;
      if (prev === 1'b1 && gp_level[idx] === 1'b0) falls++;
      prev = gp_level[idx];
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200us;
    err_total++;
    end_of_test();
  end

  // ==========================================================
  // Tests
  initial begin
    static int pt[4] = '{2, 8, 32, 64};
    rst_n_in = 1'b0;
    {addr, wdata, wr, rd, periph, misc, gp_pin} = '0;
    vpin = 6'h2a;
    err_total = 0;
    num_checks = 0;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int a = 'hf0; a <= 'hfd; a++) begin
      rchk(8'(a), (a == 'hfc) ? 8'h2a : 8'h00);
    end
    rchk(8'he0, 8'h00);
    reg_write(ADDR_SMI_CONTROL_TWO, 8'hff);
    rchk(ADDR_SMI_CONTROL_TWO, 8'h47);
    reg_write(ADDR_SPARE_F5, 8'hff);
    rchk(ADDR_SPARE_F5, 8'h00);
    reg_write(ADDR_SMI_STATUS_ONE, 8'hff);
    rchk(ADDR_SMI_STATUS_ONE, 8'h00);
    reg_write(ADDR_SMI_PIN_SELECT, 8'hff);
    rchk(ADDR_SMI_PIN_SELECT, 8'h3f);
    reg_write(ADDR_SMI_PIN_SELECT, 8'h30);
    rchk(ADDR_SMI_PIN_SELECT, 8'h30);
    chk(gp_drive, 40'h0);
    reg_write(ADDR_SMI_PIN_SELECT, 8'h2d);
    rchk(ADDR_SMI_PIN_SELECT, 8'h2d);
    chk(gp_drive, 40'h1 << 37);
    reg_write(ADDR_SMI_PIN_SELECT, 8'h08);
    rchk(ADDR_SMI_PIN_SELECT, 8'h08);
    chk(gp_drive, 40'h1);
    for (int i = 0; i < 11; i++) begin
      en = 11'h1 << i;
      reg_write(ADDR_SMI_CONTROL_ONE, en[7:0]);
      reg_write(ADDR_SMI_CONTROL_TWO, {5'h00, en[10:8]});
      set_src(~en[7:0], ~en[10:8]);
      chk(40'(irq), 40'h0);
      set_src(8'hff, 3'h7);
      chk(40'(irq), 40'h1);
      chk(40'(gp_level[0]), 40'h0);
      rchk(ADDR_SMI_STATUS_ONE, 8'hff);
      rchk(ADDR_SMI_STATUS_TWO, 8'h07);
      rchk(ADDR_SMI_STATUS_TWO, 8'h00);
      set_src(8'h00, 3'h0);
      chk(40'(irq), 40'h0);
    end
    reg_write(ADDR_SMI_CONTROL_TWO, 8'h41);
    set_src(8'h00, 3'h1);
    rchk(ADDR_SMI_STATUS_TWO, 8'h01);
    rchk(ADDR_SMI_STATUS_TWO, 8'h01);
    set_src(8'h00, 3'h0);
    reg_write(ADDR_SMI_CONTROL_TWO, 8'hc1);
    rchk(ADDR_SMI_STATUS_TWO, 8'h00);
    rchk(ADDR_SMI_CONTROL_TWO, 8'h41);
    chk(40'(irq), 40'h0);
    chk(40'(rises), 40'd12);
    reg_write(ADDR_KBD_LOCK_PIN_SELECT, 8'h11);
    @(posedge clk_in);
    gp_pin <= 40'h1 << 9;
    repeat (3) @(posedge clk_in);
    #1;
    chk(40'(kbd), 40'h1);
    @(posedge clk_in);
    gp_pin <= ~(40'h1 << 9);
    repeat (3) @(posedge clk_in);
    #1;
    chk(40'(kbd), 40'h0);
    reg_write(ADDR_BLINK1_PIN_SELECT, 8'h10);
    for (int c = 0; c < 8; c++) begin
      reg_write(ADDR_BLINK1_CONTROL, 8'((c << 1) | 1));
      measure(8);
      measure(8);
      per = pt[c % 4] * TICK;
      chk(40'(gp_drive[8]), 40'h1);
      chk(40'(falls), 40'(512 / per));
      chk(40'(lows), 40'((c < 4) ? 256 : 512 / per * TICK));
    end
    reg_write(ADDR_BLINK1_CONTROL, 8'h00);
    rchk(ADDR_BLINK1_CONTROL, 8'h00);
    chk(40'(gp_drive[8]), 40'h0);
    reg_write(ADDR_BLINK2_PIN_SELECT, 8'h18);
    reg_write(ADDR_BLINK2_CONTROL, 8'hf3);
    rchk(ADDR_BLINK2_CONTROL, 8'h03);
    measure(16);
    measure(16);
    chk(40'(falls), 40'd16);
    chk(40'(lows), 40'd256);
    reg_write(ADDR_VOLTAGE_CODE_OUT, 8'hff);
    rchk(ADDR_VOLTAGE_CODE_OUT, 8'hbf);
    chk(40'({vdrive, vlevel}), 40'h7f);
    reg_write(ADDR_VOLTAGE_CODE_OUT, 8'h15);
    rchk(ADDR_VOLTAGE_CODE_OUT, 8'h15);
    chk(40'({vdrive, vlevel}), 40'h15);
    @(posedge clk_in);
    vpin <= 6'h15;
    rchk(ADDR_VOLTAGE_CODE_IN, 8'h15);
    end_of_test();
  end
endmodule

`default_nettype wire
